// ===== inc/scda_pkg.sv
// Shared constants and types of the subsystem processor decode and addressing core
package scda_pkg;

	// ==========================================================
	// Instruction fields (vector index = 15 - documented bit number)
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned FN_LSB   = 11;
	localparam int unsigned OP_LSB   = 8;
	localparam int unsigned S_LSB    = 4;
	localparam int unsigned T_LSB    = 0;
	localparam int unsigned IND_BIT  = 10;
	localparam int unsigned MODE_LSB = 8;
	localparam int unsigned BASE_LSB = 0;

	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_STOP = 8'h00;
	localparam logic [7:0] OP_SETB = 8'h01;
	localparam logic [7:0] OP_CLRB = 8'h02;
	localparam logic [7:0] OP_CMPB = 8'h03;
	localparam logic [7:0] OP_TAB1 = 8'h06;
	localparam logic [7:0] OP_TAB2 = 8'h07;
	localparam logic [7:0] OP_CTST = 8'h08;
	localparam logic [7:0] OP_ADDI = 8'h10;
	localparam logic [7:0] OP_SUBI = 8'h11;
	localparam logic [7:0] OP_LDA  = 8'h17;
	localparam logic [4:0] F1_MAX  = 5'h02;
	localparam logic [4:0] F_ADD   = 5'h0c;
	localparam logic [4:0] F_SUB   = 5'h0d;

	// ==========================================================
	// Addressing mode selector
	localparam logic [1:0] MODE_DIR = 2'b00;
	localparam logic [1:0] MODE_B1  = 2'b01;
	localparam logic [1:0] MODE_B2  = 2'b10;
	localparam logic [1:0] MODE_REL = 2'b11;

	// ==========================================================
	// Register map and fields
	localparam logic [11:0] A_CTRL  = 12'h000;
	localparam logic [11:0] A_PC    = 12'h004;
	localparam logic [11:0] A_ACC   = 12'h008;
	localparam logic [11:0] A_B1    = 12'h00c;
	localparam logic [11:0] A_B2    = 12'h010;
	localparam logic [11:0] A_INSTR = 12'h014;
	localparam logic [11:0] A_EA    = 12'h018;
	localparam int unsigned CTRL_RESUME = 0;
	localparam int unsigned ST_HALT  = 0;
	localparam int unsigned ST_COND  = 1;
	localparam int unsigned ST_CARRY = 2;
	localparam logic [15:0] PC_RST   = 16'h0000;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {S_HALT, S_FETCH, S_DECODE, S_IND, S_OPER} scda_state_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} scda_mem_req_t;

	typedef struct packed {
		logic        ack;
		logic [15:0] data;
	} scda_mem_rsp_t;

endpackage : scda_pkg

// ===== logic/scda_core.sv
// Subsystem processor core: instruction decode, addressing modes, flags and APB access
//
// How it works
// - Words are 16 bits, bit 00 MSB.
// - Left byte bits 00-07, right 08-15.
// - No-address fields f, a, s, t decoded.
// - Single-address fields f, i, r, m decoded.
// - Base field zero-extended to sixteen bits.
// - Address arithmetic two's complement, carry untouched.
// - Direct, plus first or second index.
// - Selector 11 direct: program counter plus base.
// - Indirect 00: stored word is address.
// - Indirect 01/10: stored word plus index.
// - Indirect 11: program counter minus base.
// - Condition changes only for listed groups.
// - Carry loads only for add/subtract groups.
// - No-effect instruction still advances counter by one.
// - Selective stop ignores s and t.
// - One storage cycle, load-via-accumulator takes two.
// - Stop halts unless bypass; resume at next.
// - Opcode 01 sets accumulator bit t.
// - Opcode 02 clears accumulator bit t.
// - Opcode 03 inverts accumulator bit t.
// - Load-via-accumulator uses accumulator as base.
`timescale 1ns/10ps
module scda_core (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	// Shared core memory
	output scda_pkg::scda_mem_req_t      mem_req,
	input  wire scda_pkg::scda_mem_rsp_t mem_rsp,
	// Station control interface
	input  wire logic                    stop_bypass_input,
	input  wire logic                    resume,
	// Status
	output logic                         halted,
	output logic                         cond_flag,
	output logic                         carry_flag,
	output logic [15:0]                  pc,
	output logic [15:0]                  acc,
	output logic [15:0]                  eff_addr
);
	import scda_pkg::*;

	// ==========================================================
	// Functions
	function automatic logic [15:0] onehot(input logic [3:0] t);
		onehot = 16'h8000 >> t;
	endfunction : onehot

	function automatic logic [15:0] ext8(input logic [7:0] m);
		ext8 = {8'h00, m};
	endfunction : ext8

	function automatic logic [16:0] add17(input logic [15:0] a, input logic [15:0] b, input logic sub);
		add17 = sub ? ({1'b0, a} + {1'b0, ~b} + 17'h0_0001) : ({1'b0, a} + {1'b0, b});
	endfunction : add17

	// Pure 16-bit two's complement sum; no carry leaves it
	function automatic logic [15:0] ea_mode(input logic ind, input logic [1:0] mode, input logic [7:0] m,
			input logic [15:0] b1, input logic [15:0] b2, input logic [15:0] p, input logic [15:0] w);
		logic [15:0] base;
		base = ind ? w : ext8(m);
		case (mode)
			MODE_DIR: ea_mode = base;
			MODE_B1:  ea_mode = base + b1;
			MODE_B2:  ea_mode = base + b2;
			default:  ea_mode = ind ? p - ext8(m) : p + ext8(m);
		endcase
	endfunction : ea_mode

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == A_CTRL) || (a == A_PC) || (a == A_ACC) || (a == A_B1) ||
			(a == A_B2) || (a == A_INSTR) || (a == A_EA);
	endfunction : mapped

	// ==========================================================
	// State
	scda_state_t   st_q, st_d;
	scda_mem_req_t req_q, req_d;
	logic [15:0]   pc_q, pc_d, acc_q, acc_d, b1_q, b1_d, b2_q, b2_d;
	logic [15:0]   ir_q, ir_d, ea_q, ea_d;
	logic          cond_q, cond_d, carry_q, carry_d, halted_q, halted_d;
	logic          pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0]   prdata_q, prdata_d;
	logic          fin, halt_now, carry_ld, cond_ld;
	logic [16:0]   sum;

	// Decoded fields of the held instruction
	logic [7:0]  op_byte;
	logic [4:0]  fn;
	logic [3:0]  s_fld, t_fld;
	logic        ind;
	logic [1:0]  mode;
	logic [7:0]  base;
	logic        fmt1;
	logic [15:0] nxt_pc;
	logic        apb_done, wr_go, wr_pc, wr_acc, wr_b1, wr_b2;

	assign op_byte = ir_q[OP_LSB +: 8];
	assign fn      = ir_q[FN_LSB +: 5];
	assign s_fld   = ir_q[S_LSB +: 4];
	assign t_fld   = ir_q[T_LSB +: 4];
	assign ind     = ir_q[IND_BIT];
	assign mode    = ir_q[MODE_LSB +: 2];
	assign base    = ir_q[BASE_LSB +: 8];
	assign fmt1    = (fn <= F1_MAX);
	assign nxt_pc  = pc_q + 16'h0001;

	// ==========================================================
	// APB write strobes; a write lands at the completing edge
	assign apb_done = psel && penable && pready_q && pwrite && mapped(paddr);
	assign wr_go    = apb_done && (paddr == A_CTRL) && pwdata[CTRL_RESUME];
	assign wr_pc    = apb_done && (paddr == A_PC);
	assign wr_acc   = apb_done && (paddr == A_ACC);
	assign wr_b1    = apb_done && (paddr == A_B1);
	assign wr_b2    = apb_done && (paddr == A_B2);

	// ==========================================================
	// Processor sequencing
	always_comb begin
		st_d     = st_q;
		req_d    = req_q;
		pc_d     = pc_q;
		acc_d    = acc_q;
		b1_d     = b1_q;
		b2_d     = b2_q;
		ir_d     = ir_q;
		ea_d     = ea_q;
		cond_d   = cond_q;
		carry_d  = carry_q;
		fin      = 1'b0;
		halt_now = 1'b0;
		carry_ld = 1'b0;
		cond_ld  = 1'b0;
		sum      = 17'h0_0000;
		case (st_q)
			S_HALT: begin
				// Register writes only while stopped, so software never races the sequencer
				if (wr_pc) pc_d = pwdata[15:0];
				if (wr_acc) acc_d = pwdata[15:0];
				if (wr_b1) b1_d = pwdata[15:0];
				if (wr_b2) b2_d = pwdata[15:0];
				if (resume || wr_go) begin
					st_d  = S_FETCH;
					req_d = '{valid: 1'b1, addr: wr_pc ? pwdata[15:0] : pc_q};
				end
			end
			S_FETCH: begin
				if (mem_rsp.ack) begin
					ir_d        = mem_rsp.data;
					req_d.valid = 1'b0;
					st_d        = S_DECODE;
				end
			end
			S_DECODE: begin
				if (fmt1) begin
					case (op_byte)
						OP_STOP: begin
							fin      = 1'b1;
							halt_now = !stop_bypass_input;
						end
						OP_SETB: begin
							acc_d = acc_q | onehot(t_fld);
							fin   = 1'b1;
						end
						OP_CLRB: begin
							acc_d = acc_q & ~onehot(t_fld);
							fin   = 1'b1;
						end
						OP_CMPB: begin
							acc_d = acc_q ^ onehot(t_fld);
							fin   = 1'b1;
						end
						OP_TAB1: begin
							b1_d = acc_q + ext8(base);
							fin  = 1'b1;
						end
						OP_TAB2: begin
							b2_d = acc_q + ext8(base);
							fin  = 1'b1;
						end
						OP_CTST: begin
							cond_ld = 1'b1;
							cond_d  = (s_fld[0] && |(acc_q & onehot(t_fld))) || (s_fld[1] && carry_q) ||
								(s_fld[2] && ^acc_q);
							fin     = 1'b1;
						end
						OP_ADDI, OP_SUBI: begin
							sum      = add17(acc_q, ext8(base), op_byte == OP_SUBI);
							acc_d    = sum[15:0];
							carry_ld = 1'b1;
							carry_d  = sum[16];
							fin      = 1'b1;
						end
						OP_LDA: begin
							// Second storage cycle reads through the accumulator
							ea_d  = acc_q + ext8(base);
							req_d = '{valid: 1'b1, addr: acc_q + ext8(base)};
							st_d  = S_OPER;
						end
						default: fin = 1'b1;
					endcase
				end else if (ind && (mode != MODE_REL)) begin
					if ((fn == F_ADD) || (fn == F_SUB)) begin
						req_d = '{valid: 1'b1, addr: ext8(base)};
						st_d  = S_IND;
					end else begin
						fin = 1'b1;
					end
				end else begin
					ea_d = ea_mode(ind, mode, base, b1_q, b2_q, pc_q, WORD_RST);
					if ((fn == F_ADD) || (fn == F_SUB)) begin
						req_d = '{valid: 1'b1, addr: ea_mode(ind, mode, base, b1_q, b2_q, pc_q, WORD_RST)};
						st_d  = S_OPER;
					end else begin
						fin = 1'b1;
					end
				end
			end
			S_IND: begin
				if (mem_rsp.ack) begin
					ea_d  = ea_mode(1'b1, mode, base, b1_q, b2_q, pc_q, mem_rsp.data);
					req_d = '{valid: 1'b1, addr: ea_mode(1'b1, mode, base, b1_q, b2_q, pc_q, mem_rsp.data)};
					st_d  = S_OPER;
				end
			end
			S_OPER: begin
				if (mem_rsp.ack) begin
					req_d.valid = 1'b0;
					fin         = 1'b1;
					if (fmt1) begin
						acc_d = mem_rsp.data;
					end else begin
						sum      = add17(acc_q, mem_rsp.data, fn == F_SUB);
						acc_d    = sum[15:0];
						carry_ld = 1'b1;
						carry_d  = sum[16];
					end
				end
			end
			default: st_d = S_HALT;
		endcase
		if (fin) begin
			pc_d = nxt_pc;
			if (halt_now) begin
				st_d = S_HALT;
			end else begin
				st_d  = S_FETCH;
				req_d = '{valid: 1'b1, addr: nxt_pc};
			end
		end
		halted_d = (st_d == S_HALT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= S_HALT;
			req_q    <= '{valid: 1'b0, addr: 16'h0000};
			pc_q     <= PC_RST;
			acc_q    <= WORD_RST;
			b1_q     <= WORD_RST;
			b2_q     <= WORD_RST;
			ir_q     <= WORD_RST;
			ea_q     <= WORD_RST;
			cond_q   <= 1'b0;
			carry_q  <= 1'b0;
			halted_q <= 1'b1;
		end else begin
			st_q     <= st_d;
			req_q    <= req_d;
			pc_q     <= pc_d;
			acc_q    <= acc_d;
			b1_q     <= b1_d;
			b2_q     <= b2_d;
			ir_q     <= ir_d;
			ea_q     <= ea_d;
			cond_q   <= cond_d;
			carry_q  <= carry_d;
			halted_q <= halted_d;
		end
	end

	// ==========================================================
	// APB slave: one wait state, read data captured in the first access cycle
	always_comb begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		if (psel && penable && !pready_q) begin
			pready_d  = 1'b1;
			pslverr_d = !mapped(paddr);
			case (paddr)
				A_CTRL:  prdata_d = {29'h0000_0000, carry_q, cond_q, halted_q};
				A_PC:    prdata_d = {16'h0000, pc_q};
				A_ACC:   prdata_d = {16'h0000, acc_q};
				A_B1:    prdata_d = {16'h0000, b1_q};
				A_B2:    prdata_d = {16'h0000, b2_q};
				A_INSTR: prdata_d = {16'h0000, ir_q};
				A_EA:    prdata_d = {16'h0000, ea_q};
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign prdata     = prdata_q;
	assign mem_req    = req_q;
	assign halted     = halted_q;
	assign cond_flag  = cond_q;
	assign carry_flag = carry_q;
	assign pc         = pc_q;
	assign acc        = acc_q;
	assign eff_addr   = ea_q;

	// ==========================================================
	// Assertions
	pc_advance_a: assert property (@(posedge pclk) disable iff (!presetn)
		fin |=> pc_q == 16'($past(pc_q) + 16'h0001)) else $error("pc not advanced by one");
	next_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
		fin && !halt_now |=> req_q.valid && req_q.addr == pc_q) else $error("next fetch wrong");
	set_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_DECODE && fmt1 && op_byte == OP_SETB |=> acc_q == ($past(acc_q) | onehot($past(t_fld))))
		else $error("set bit wrong");
	clear_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_DECODE && fmt1 && op_byte == OP_CLRB |=> acc_q == ($past(acc_q) & ~onehot($past(t_fld))))
		else $error("clear bit wrong");
	flip_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_DECODE && fmt1 && op_byte == OP_CMPB |=> acc_q == ($past(acc_q) ^ onehot($past(t_fld))))
		else $error("complement bit wrong");
	stop_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_DECODE && fmt1 && op_byte == OP_STOP |=> halted_q == !$past(stop_bypass_input))
		else $error("selective stop wrong");
	carry_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!carry_ld |=> $stable(carry_q)) else $error("carry changed");
	cond_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cond_ld |=> $stable(cond_q)) else $error("condition changed");
	direct_ea_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_DECODE && !fmt1 && !ind && mode == MODE_DIR |=> ea_q == {8'h00, $past(base)})
		else $error("direct address wrong");
	lda_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_DECODE && fmt1 && op_byte == OP_LDA |=> st_q == S_OPER && req_q.valid)
		else $error("load via accumulator lacks second cycle");

endmodule : scda_core

// ===== testbench/scda_mem_model.sv
// Behavioural shared core memory answering storage requests of the core
`timescale 1ns/10ps
module scda_mem_model (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// Storage port
	input  wire scda_pkg::scda_mem_req_t req,
	output scda_pkg::scda_mem_rsp_t      rsp,
	// Answer delay in cycles
	input  wire logic [3:0]              lat
);
	import scda_pkg::*;
	logic [15:0] words [0:4095];
	logic [3:0]  wait_q;

	// ==========================================================
	// Answer
	// Data toggles outside the ack cycle so a stale word is never taken by luck
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 4'h0;
			rsp    <= '0;
		end else if (req.valid && !rsp.ack && wait_q >= lat) begin
			rsp    <= {1'b1, words[req.addr[11:0]]};
			wait_q <= 4'h0;
		end else begin
			rsp    <= {1'b0, ~rsp.data};
			wait_q <= (req.valid && !rsp.ack) ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule : scda_mem_model

// ===== testbench/subsystem_cpu_decode_addressing_test.sv
// Self-checking bench running short programs on the decode and addressing core
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module subsystem_cpu_decode_addressing_test;
	import scda_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, r, q;
	scda_mem_req_t mem_req;
	scda_mem_rsp_t mem_rsp;
	logic          stop_bypass_input, resume, halted, cond_flag, carry_flag, cy, cd;
	logic [15:0]   pc, acc, eff_addr, byp_end, a, b1v, ea, p, idx;
	logic [16:0]   s;
	logic [3:0]    lat;
	logic [31:0]   seed = 32'h0000_0017;
	logic [32:0]   notes[$];
	logic [32:0]   note;
	int            n_fail, check_count, acks;

	scda_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.mem_req(mem_req), .mem_rsp(mem_rsp), .stop_bypass_input(stop_bypass_input), .resume(resume),
		.halted(halted), .cond_flag(cond_flag), .carry_flag(carry_flag), .pc(pc), .acc(acc),
		.eff_addr(eff_addr));
	scda_mem_model mem (.pclk(pclk), .presetn(presetn), .req(mem_req), .rsp(mem_rsp), .lat(lat));

	always #4 pclk = ~pclk;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never drives psel twice in one step
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] ad, input logic [15:0] v);
		apb(1'b1, ad, {16'h0000, v});
	endtask : wr

	task automatic rd(input logic [11:0] ad, input logic [15:0] v);
		notes.push_back({17'h0_0000, v});
		apb(1'b0, ad, 32'h0000_0000);
		// Core is stopped here, so the status pins must show the same values
		case (ad)
			A_PC:    `CHK(pc, v)
			A_ACC:   `CHK(acc, v)
			A_EA:    `CHK(eff_addr, v)
			A_CTRL:  `CHK({carry_flag, cond_flag, halted}, v[2:0])
			default: ;
		endcase
	endtask : rd

	// Loads the counter, resumes by pin or register, waits for the stop
	task automatic run(input logic [15:0] p0, input logic pin, input int n_ack);
		int n;
		n = 0;
		wr(A_PC, p0);
		lat  <= (lat + 4'h1) & 4'h3;
		acks = 0;
		if (pin) begin
			resume <= 1'b1;
			@(posedge pclk);
			resume <= 1'b0;
		end else begin
			wr(A_CTRL, 16'h0001);
		end
		repeat (2) @(posedge pclk);
		while (halted !== 1'b1 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		`CHK(halted, 1'b1)
		`CHK(acks, n_ack)
	endtask : run

	task automatic summarize();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// ==========================================================
	// Watchers
	always @(posedge pclk) begin
		if (presetn === 1'b1 && psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
			note = notes.pop_front();
			`CHK({pslverr, prdata}, note)
		end
	end
	always @(posedge pclk) if (mem_rsp.ack === 1'b1 && mem_req.valid === 1'b1) acks <= acks + 1;
	always @(posedge pclk) if (mem_req.valid === 1'b1 && mem_req.addr === byp_end) stop_bypass_input <= 1'b0;

	initial begin
		repeat (40000) @(posedge pclk);
		n_fail++;
		summarize();
	end

	// ==========================================================
	// Scenarios
	initial begin
		{pclk, presetn, psel, penable, pwrite, resume, stop_bypass_input} = '0;
		{paddr, pwdata, lat, byp_end} = {12'h000, 32'h0, 4'h0, 16'hffff};
		for (int i = 0; i < 4096; i++) begin
			r = xs();
			mem.words[i] = r[15:0];
		end
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_CTRL, 16'h0001);
		notes.push_back({1'b1, 32'h0000_0000});
		apb(1'b0, 12'h01c, 32'h0000_0000);
		// Bit ops, immediate add and subtract, index load, load via accumulator, then stop
		r = xs();
		q = xs();
		mem.words[12'h020] = {12'h010, r[3:0]};
		mem.words[12'h021] = {12'h020, r[7:4]};
		mem.words[12'h022] = {12'h030, r[11:8]};
		mem.words[12'h023] = {8'h10, q[7:0]};
		mem.words[12'h024] = {8'h11, q[15:8]};
		mem.words[12'h025] = {7'h03, r[12], q[23:16]};
		mem.words[12'h026] = {8'h17, q[31:24]};
		mem.words[12'h027] = 16'h00a5;
		a = r[31:16];
		// Bit t counts from the most significant end, so vector index is 15 - t
		a[~r[3:0]] = 1'b1;
		a[~r[7:4]] = 1'b0;
		a[~r[11:8]] = ~a[~r[11:8]];
		s = {1'b0, a} + {9'h000, q[7:0]};
		s = {1'b0, s[15:0]} + {1'b0, ~{8'h00, q[15:8]}} + 17'h0_0001;
		cy = s[16];
		b1v = s[15:0] + {8'h00, q[23:16]};
		ea = s[15:0] + {8'h00, q[31:24]};
		a = mem.words[ea[11:0]];
		wr(A_ACC, r[31:16]);
		run(16'h0020, 1'b0, 9);
		rd(A_ACC, a);
		rd(r[12] ? A_B2 : A_B1, b1v);
		rd(A_PC, 16'h0028);
		rd(A_CTRL, {13'h0000, cy, 1'b0, 1'b1});
		// Bypassed stop runs on; condition test; halt at the second stop
		r = xs();
		mem.words[12'h040] = {8'h00, r[23:16]};
		mem.words[12'h041] = {12'h081, r[19:16]};
		mem.words[12'h042] = {12'h010, r[27:24]};
		mem.words[12'h043] = 16'h0000;
		a = r[15:0];
		cd = a[~r[19:16]];
		a[~r[27:24]] = 1'b1;
		wr(A_ACC, r[15:0]);
		stop_bypass_input <= 1'b1;
		byp_end <= 16'h0043;
		run(16'h0040, 1'b1, 4);
		rd(A_ACC, a);
		rd(A_PC, 16'h0044);
		rd(A_CTRL, {13'h0000, cy, cd, 1'b1});
		// All eight addressing modes through a memory add (even modes) or subtract (odd modes)
		for (logic [3:0] md = 4'h0; md < 4'h8; md++) begin
			r = xs();
			q = xs();
			p = {11'h004, md[2:0], 2'b00};
			mem.words[{6'h03, r[5:0]}] = q[15:0];
			mem.words[p[11:0]] = {4'h6, md[0], md[2:0], 2'b11, r[5:0]};
			mem.words[p[11:0] + 12'h001] = 16'h0000;
			idx = (md[1:0] == 2'b01) ? r[31:16] : (md[1:0] == 2'b10) ? q[31:16] : 16'h0000;
			if (md[1:0] == 2'b11)
				ea = md[2] ? p - {8'h00, 2'b11, r[5:0]} : p + {8'h00, 2'b11, r[5:0]};
			else
				ea = (md[2] ? q[15:0] : {8'h00, 2'b11, r[5:0]}) + idx;
			a = mem.words[ea[11:0]];
			// Odd modes subtract from a cleared accumulator
			s = md[0] ? ({1'b0, ~a} + 17'h0_0001) : {1'b0, a};
			wr(A_B1, r[31:16]);
			wr(A_B2, q[31:16]);
			wr(A_ACC, 16'h0000);
			run(p, md[0], (md[2] && md[1:0] != 2'b11) ? 4 : 3);
			rd(A_EA, ea);
			rd(A_ACC, s[15:0]);
			rd(A_PC, p + 16'h0002);
			rd(A_CTRL, {13'h0000, s[16], cd, 1'b1});
		end
		repeat (4) @(posedge pclk);
		summarize();
	end
endmodule : subsystem_cpu_decode_addressing_test
